/* File: rtl/tat_pkg.sv */
/*
 * Constants, field layouts and types for the asynchronous 8-bit timer with
 * compare output. Assumes a single register port with a 2-bit address.
 */
// How it works
// - any nonzero compare output mode hands the pin to the compare output
// - non-PWM: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast PWM: 10 clear on match, set at TOP; 11 inverse; 01 reserved
// - phase correct: 10 clear on up match, set on down match; 11 inverse
// - PWM with compare at TOP and high mode bit: skip match, act at TOP
// - clock select: stop, undivided, or divided by 8..1024
// - counter register reads and writes the live 8-bit counter
// - a counter write blocks the match on the next timer clock
// - compare value is checked every count; a match raises a flag and drives the pin
// - external clock enable picks pin clock; crystal runs only when it is zero
// - async select zero uses the system clock, one uses the oscillator pin
// - register contents need not survive a change of async select
// - async writes set that register's busy flag until the transfer lands
// - counter reads live value; compare and control read the holding register
// - async writes pass a holding register, landing after two oscillator edges
// - waveform mode picks normal, phase correct, clear-on-match or fast PWM
package tat_pkg;

	// -----------------------------------------------------------------
	// register map
	// -----------------------------------------------------------------
	localparam int          ADDR_W      = 2;
	localparam logic [1:0]  OFS_CONTROL = 2'h0;
	localparam logic [1:0]  OFS_COUNTER = 2'h1;
	localparam logic [1:0]  OFS_COMPARE = 2'h2;
	localparam logic [1:0]  OFS_STATUS  = 2'h3;
	localparam logic [7:0]  RESET_VALUE = 8'h00;

	// -----------------------------------------------------------------
	// field positions
	// -----------------------------------------------------------------
	localparam int CTL_FORCE_BIT = 7;          // write-only bit, has no effect, reads zero
	localparam int CTL_WGM_LO    = 6;
	localparam int CTL_COM_HI    = 5;
	localparam int CTL_COM_LO    = 4;
	localparam int CTL_WGM_HI    = 3;
	localparam int CTL_CS_HI     = 2;
	localparam int CTL_CS_LO     = 0;
	localparam int STS_EXT_BIT   = 4;
	localparam int STS_ASYNC_BIT = 3;

	// holding-register entry index, equal to its busy flag position
	localparam int NUM_HELD = 3;
	localparam int IDX_CTL  = 0;
	localparam int IDX_CMP  = 1;
	localparam int IDX_CNT  = 2;

	// -----------------------------------------------------------------
	// mode encodings
	// -----------------------------------------------------------------
	localparam logic [1:0] WGM_NORMAL = 2'h0;
	localparam logic [1:0] WGM_PHASE  = 2'h1;
	localparam logic [1:0] WGM_CTC    = 2'h2;
	localparam logic [1:0] WGM_FAST   = 2'h3;
	localparam logic [1:0] COM_OFF    = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR  = 2'h2;
	localparam logic [1:0] COM_SET    = 2'h3;
	localparam logic [2:0] CS_STOP    = 3'h0;
	localparam logic [2:0] CS_DIV1    = 3'h1;
	localparam logic [2:0] CS_DIV8    = 3'h2;
	localparam logic [2:0] CS_DIV32   = 3'h3;
	localparam logic [2:0] CS_DIV64   = 3'h4;
	localparam logic [2:0] CS_DIV128  = 3'h5;
	localparam logic [2:0] CS_DIV256  = 3'h6;
	localparam logic [2:0] CS_DIV1024 = 3'h7;

	// prescaler tap masks: tick when all masked bits are one
	localparam int         PRE_W      = 10;
	localparam logic [9:0] MASK_8     = 10'h007;
	localparam logic [9:0] MASK_32    = 10'h01F;
	localparam logic [9:0] MASK_64    = 10'h03F;
	localparam logic [9:0] MASK_128   = 10'h07F;
	localparam logic [9:0] MASK_256   = 10'h0FF;
	localparam logic [9:0] MASK_1024  = 10'h3FF;

	// -----------------------------------------------------------------
	// counter limits and transfer timing
	// -----------------------------------------------------------------
	localparam logic [7:0] TOP_MAX     = 8'hFF;
	localparam logic [7:0] BOTTOM      = 8'h00;
	localparam logic [1:0] XFER_LAST   = 2'h1;  // second oscillator edge lands it

	typedef enum logic [1:0] {
		TAT_DIR_UP   = 2'h1,
		TAT_DIR_DOWN = 2'h2
	} tat_dir_t;

endpackage : tat_pkg

/* File: rtl/tat_prescaler.sv */
/*
 * Prescaler: divides the timer source tick by the selected ratio.
 * Assumes src_tick is a one-cycle pulse synchronous to mclk.
 */
`timescale 1ns/10ps
`default_nettype none
module tat_prescaler (
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       src_tick,
	input  wire logic [2:0] clock_sel,
	output logic            timer_tick
);
	logic [tat_pkg::PRE_W-1:0] pre_cnt;
	logic [tat_pkg::PRE_W-1:0] next_pre_cnt;
	logic [tat_pkg::PRE_W-1:0] tap_mask;

	// -----------------------------------------------------------------
	// free-running divider on the source tick
	// -----------------------------------------------------------------
	// free running, so a new ratio may give one short first period
	always_comb begin
		next_pre_cnt = src_tick ? pre_cnt + 1'h1 : pre_cnt;
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pre_cnt <= '0;
		end else begin
			pre_cnt <= next_pre_cnt;
		end
	end

	always_comb begin
		tap_mask   = '0;
		timer_tick = 1'h0;
		unique case (clock_sel)
			tat_pkg::CS_STOP:    timer_tick = 1'h0;
			tat_pkg::CS_DIV1:    timer_tick = src_tick;
			tat_pkg::CS_DIV8:    tap_mask = tat_pkg::MASK_8;
			tat_pkg::CS_DIV32:   tap_mask = tat_pkg::MASK_32;
			tat_pkg::CS_DIV64:   tap_mask = tat_pkg::MASK_64;
			tat_pkg::CS_DIV128:  tap_mask = tat_pkg::MASK_128;
			tat_pkg::CS_DIV256:  tap_mask = tat_pkg::MASK_256;
			tat_pkg::CS_DIV1024: tap_mask = tat_pkg::MASK_1024;
		endcase
		if (tap_mask != '0) begin
			timer_tick = src_tick && ((pre_cnt & tap_mask) == tap_mask);
		end
	end

endmodule : tat_prescaler
`default_nettype wire

/* File: rtl/tat_timer.sv */
/*
 * 8-bit timer with compare output, clock select and asynchronous
 * write-transfer path. Assumes the oscillator pin is sampled on mclk and
 * toggles much slower than mclk (at least four mclk per oscillator period).
 */
`timescale 1ns/10ps
`default_nettype none
module tat_timer (
	input  wire logic                       mclk,
	input  wire logic                       reset,
	input  wire logic [tat_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [7:0]                 reg_rdata,
	input  wire logic                       osc_input_pin,
	output logic                            compare_output_pin,
	output logic                            compare_output_enable,
	output logic                            compare_match_event,
	output logic                            crystal_osc_run,
	output logic                            ext_clock_input_enable
);
	// -----------------------------------------------------------------
	// declarations
	// -----------------------------------------------------------------
	logic [1:0]             osc_sync;
	logic                   osc_prev;
	logic                   osc_rise;
	logic                   async_clock_select;
	logic                   ext_clock_enable;
	logic                   next_async_sel;
	logic                   next_ext_en;
	logic [7:0]             hold      [tat_pkg::NUM_HELD];
	logic [7:0]             next_hold [tat_pkg::NUM_HELD];
	logic [1:0]             xfer      [tat_pkg::NUM_HELD];
	logic [1:0]             next_xfer [tat_pkg::NUM_HELD];
	logic [7:0]             load_val  [tat_pkg::NUM_HELD];
	logic [tat_pkg::NUM_HELD-1:0] busy;
	logic [tat_pkg::NUM_HELD-1:0] next_busy;
	logic [tat_pkg::NUM_HELD-1:0] load;
	logic [tat_pkg::NUM_HELD-1:0] wr_sel;
	logic [7:0]             timer_control;
	logic [7:0]             counter_value;
	logic [7:0]             compare_value;
	logic [7:0]             next_ctl;
	logic [7:0]             next_cnt;
	logic [7:0]             next_cmp;
	tat_pkg::tat_dir_t      dir;
	tat_pkg::tat_dir_t      next_dir;
	logic                   match_block;
	logic                   next_block;
	logic                   next_oc;
	logic                   next_oc_en;
	logic                   next_event;
	logic                   next_xtal;
	logic                   next_ext_buf;
	logic [7:0]             next_rdata;
	logic                   src_tick;
	logic                   timer_tick;
	logic [1:0]             waveform_mode_select;
	logic [1:0]             compare_output_mode;
	logic [2:0]             clock_select_field;
	logic [7:0]             top_value;
	logic                   raw_match;
	logic                   pwm_mode;
	logic                   ignore_match;
	logic                   eff_match;

	// -----------------------------------------------------------------
	// oscillator pin sampling
	// -----------------------------------------------------------------
	// first stage feeds only the second stage
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			osc_sync <= 2'h0;
			osc_prev <= 1'h0;
		end else begin
			osc_sync <= {osc_sync[0], osc_input_pin};
			osc_prev <= osc_sync[1];
		end
	end
	assign osc_rise = osc_sync[1] && !osc_prev;

	assign src_tick = async_clock_select ? osc_rise : 1'h1;

	// -----------------------------------------------------------------
	// field decode and write select
	// -----------------------------------------------------------------
	assign waveform_mode_select = {timer_control[tat_pkg::CTL_WGM_HI], timer_control[tat_pkg::CTL_WGM_LO]};
	assign compare_output_mode  = timer_control[tat_pkg::CTL_COM_HI:tat_pkg::CTL_COM_LO];
	assign clock_select_field   = timer_control[tat_pkg::CTL_CS_HI:tat_pkg::CTL_CS_LO];
	assign wr_sel[tat_pkg::IDX_CTL] = reg_wr && (reg_addr == tat_pkg::OFS_CONTROL);
	assign wr_sel[tat_pkg::IDX_CMP] = reg_wr && (reg_addr == tat_pkg::OFS_COMPARE);
	assign wr_sel[tat_pkg::IDX_CNT] = reg_wr && (reg_addr == tat_pkg::OFS_COUNTER);

	tat_prescaler u_prescaler (
		.mclk       (mclk),
		.reset      (reset),
		.src_tick   (src_tick),
		.clock_sel  (clock_select_field),
		.timer_tick (timer_tick)
	);

	// -----------------------------------------------------------------
	// holding registers and busy flags, one per buffered register
	// -----------------------------------------------------------------
	for (genvar i = 0; i < tat_pkg::NUM_HELD; i++) begin : g_held
		always_comb begin
			next_hold[i] = wr_sel[i] ? reg_wdata : hold[i];
			next_busy[i] = busy[i];
			next_xfer[i] = xfer[i];
			load[i]      = 1'h0;
			load_val[i]  = wr_sel[i] ? reg_wdata : hold[i];
			if (!async_clock_select) begin
				next_busy[i] = 1'h0;
				next_xfer[i] = 2'h0;
				load[i]      = wr_sel[i];
			end else if (wr_sel[i]) begin
				// a new write restarts the transfer, so the set wins
				next_busy[i] = 1'h1;
				next_xfer[i] = 2'h0;
			end else if (busy[i] && osc_rise) begin
				if (xfer[i] == tat_pkg::XFER_LAST) begin
					next_busy[i] = 1'h0;
					next_xfer[i] = 2'h0;
					load[i]      = 1'h1;
				end else begin
					next_xfer[i] = xfer[i] + 2'h1;
				end
			end
		end

		always_ff @(posedge mclk or posedge reset) begin
			if (reset) begin
				hold[i] <= tat_pkg::RESET_VALUE;
				busy[i] <= 1'h0;
				xfer[i] <= 2'h0;
			end else begin
				hold[i] <= next_hold[i];
				busy[i] <= next_busy[i];
				xfer[i] <= next_xfer[i];
			end
		end
	end

	// -----------------------------------------------------------------
	// counter, compare and waveform output
	// -----------------------------------------------------------------
	assign top_value    = (waveform_mode_select == tat_pkg::WGM_CTC) ? compare_value : tat_pkg::TOP_MAX;
	assign pwm_mode     = (waveform_mode_select == tat_pkg::WGM_PHASE) || (waveform_mode_select == tat_pkg::WGM_FAST);
	assign raw_match    = (counter_value == compare_value) && !match_block;
	assign ignore_match = pwm_mode && compare_output_mode[1] && (compare_value == tat_pkg::TOP_MAX);
	assign eff_match    = raw_match && !ignore_match;

	always_comb begin
		next_cnt   = counter_value;
		next_dir   = dir;
		next_block = match_block;
		next_oc    = compare_output_pin;
		next_event = 1'h0;
		next_ctl   = load[tat_pkg::IDX_CTL] ? load_val[tat_pkg::IDX_CTL] : timer_control;
		next_ctl[tat_pkg::CTL_FORCE_BIT] = 1'h0;
		next_cmp   = load[tat_pkg::IDX_CMP] ? load_val[tat_pkg::IDX_CMP] : compare_value;
		if (load[tat_pkg::IDX_CNT]) begin
			next_cnt   = load_val[tat_pkg::IDX_CNT];
			next_block = 1'h1;
		end else if (timer_tick) begin
			next_block = 1'h0;
			next_event = raw_match;
			unique case (waveform_mode_select)
				tat_pkg::WGM_CTC: next_cnt = (counter_value == top_value) ? tat_pkg::BOTTOM : counter_value + 8'h01;
				tat_pkg::WGM_PHASE: begin
					unique case (dir)
						tat_pkg::TAT_DIR_UP: begin
							if (counter_value == tat_pkg::TOP_MAX) begin
								next_dir = tat_pkg::TAT_DIR_DOWN;
								next_cnt = counter_value - 8'h01;
							end else begin
								next_cnt = counter_value + 8'h01;
							end
						end
						tat_pkg::TAT_DIR_DOWN: begin
							if (counter_value == tat_pkg::BOTTOM) begin
								next_dir = tat_pkg::TAT_DIR_UP;
								next_cnt = counter_value + 8'h01;
							end else begin
								next_cnt = counter_value - 8'h01;
							end
						end
					endcase
				end
				default: next_cnt = counter_value + 8'h01;
			endcase
			// output action; mode 01 in PWM is reserved and does nothing
			unique case (waveform_mode_select)
				tat_pkg::WGM_NORMAL, tat_pkg::WGM_CTC: begin
					if (eff_match) begin
						unique case (compare_output_mode)
							tat_pkg::COM_OFF:    next_oc = compare_output_pin;
							tat_pkg::COM_TOGGLE: next_oc = !compare_output_pin;
							tat_pkg::COM_CLEAR:  next_oc = 1'h0;
							tat_pkg::COM_SET:    next_oc = 1'h1;
						endcase
					end
				end
				tat_pkg::WGM_FAST: begin
					if (compare_output_mode[1] && eff_match) begin
						next_oc = compare_output_mode[0];
					end else if (compare_output_mode[1] && counter_value == tat_pkg::TOP_MAX) begin
						next_oc = !compare_output_mode[0];
					end
				end
				tat_pkg::WGM_PHASE: begin
					if (compare_output_mode[1] && eff_match) begin
						next_oc = (dir == tat_pkg::TAT_DIR_UP) ? compare_output_mode[0] : !compare_output_mode[0];
					end else if (ignore_match && counter_value == tat_pkg::TOP_MAX) begin
						next_oc = !compare_output_mode[0];
					end
				end
			endcase
		end
	end

	// no attempt is made to shield contents across async select changes
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			timer_control       <= tat_pkg::RESET_VALUE;
			counter_value       <= tat_pkg::RESET_VALUE;
			compare_value       <= tat_pkg::RESET_VALUE;
			dir                 <= tat_pkg::TAT_DIR_UP;
			match_block         <= 1'h0;
			compare_output_pin  <= 1'h0;
			compare_match_event <= 1'h0;
		end else begin
			timer_control       <= next_ctl;
			counter_value       <= next_cnt;
			compare_value       <= next_cmp;
			dir                 <= next_dir;
			match_block         <= next_block;
			compare_output_pin  <= next_oc;
			compare_match_event <= next_event;
		end
	end

	// -----------------------------------------------------------------
	// status bits, pin controls and read port
	// -----------------------------------------------------------------
	always_comb begin
		next_async_sel = async_clock_select;
		next_ext_en    = ext_clock_enable;
		if (reg_wr && reg_addr == tat_pkg::OFS_STATUS) begin
			next_async_sel = reg_wdata[tat_pkg::STS_ASYNC_BIT];
			next_ext_en    = reg_wdata[tat_pkg::STS_EXT_BIT];
		end
		next_oc_en   = (compare_output_mode != tat_pkg::COM_OFF);
		next_xtal    = async_clock_select && !ext_clock_enable;
		next_ext_buf = async_clock_select && ext_clock_enable;
		next_rdata   = 8'h00;
		if (reg_rd) begin
			// held values for compare and control
			unique case (reg_addr)
				tat_pkg::OFS_CONTROL: next_rdata = {1'h0, hold[tat_pkg::IDX_CTL][6:0]};
				tat_pkg::OFS_COUNTER: next_rdata = counter_value;
				tat_pkg::OFS_COMPARE: next_rdata = hold[tat_pkg::IDX_CMP];
				tat_pkg::OFS_STATUS:  next_rdata = {3'h0, ext_clock_enable, async_clock_select, busy};
			endcase
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			async_clock_select     <= 1'h0;
			ext_clock_enable       <= 1'h0;
			compare_output_enable  <= 1'h0;
			crystal_osc_run        <= 1'h0;
			ext_clock_input_enable <= 1'h0;
			reg_rdata              <= 8'h00;
		end else begin
			async_clock_select     <= next_async_sel;
			ext_clock_enable       <= next_ext_en;
			compare_output_enable  <= next_oc_en;
			crystal_osc_run        <= next_xtal;
			ext_clock_input_enable <= next_ext_buf;
			reg_rdata              <= next_rdata;
		end
	end

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence s_cmp_async_write;
		reg_wr && reg_addr == tat_pkg::OFS_COMPARE && async_clock_select;
	endsequence
	sequence s_cmp_last_edge;
		async_clock_select && busy[tat_pkg::IDX_CMP] && osc_rise && xfer[tat_pkg::IDX_CMP] == tat_pkg::XFER_LAST && !reg_wr;
	endsequence

	property p_pin_override;
		1 |=> compare_output_enable == ($past(compare_output_mode) != tat_pkg::COM_OFF);
	endproperty
	a_pin_override: assert property (p_pin_override) else $error("pin override wrong");
	property p_toggle;
		timer_tick && !pwm_mode && compare_output_mode == tat_pkg::COM_TOGGLE && raw_match && !load[tat_pkg::IDX_CNT]
			|=> compare_output_pin != $past(compare_output_pin);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle missed");
	property p_fast_top;
		timer_tick && waveform_mode_select == tat_pkg::WGM_FAST && compare_output_mode == tat_pkg::COM_CLEAR
			&& counter_value == tat_pkg::TOP_MAX && !load[tat_pkg::IDX_CNT] |=> compare_output_pin;
	endproperty
	a_fast_top: assert property (p_fast_top) else $error("fast PWM top set missed");
	property p_phase_up;
		timer_tick && waveform_mode_select == tat_pkg::WGM_PHASE && compare_output_mode == tat_pkg::COM_CLEAR
			&& dir == tat_pkg::TAT_DIR_UP && eff_match && !load[tat_pkg::IDX_CNT] |=> !compare_output_pin;
	endproperty
	a_phase_up: assert property (p_phase_up) else $error("phase up clear missed");
	property p_stopped;
		clock_select_field == tat_pkg::CS_STOP |-> !timer_tick;
	endproperty
	a_stopped: assert property (p_stopped) else $error("stopped timer ticked");
	property p_sync_cnt_write;
		reg_wr && reg_addr == tat_pkg::OFS_COUNTER && !async_clock_select |=> counter_value == $past(reg_wdata);
	endproperty
	a_sync_cnt_write: assert property (p_sync_cnt_write) else $error("counter write lost");
	property p_block;
		load[tat_pkg::IDX_CNT] ##1 (timer_tick && !load[tat_pkg::IDX_CNT]) |=> !compare_match_event;
	endproperty
	a_block: assert property (p_block) else $error("match after counter write");
	property p_match_event;
		timer_tick && raw_match && !load[tat_pkg::IDX_CNT] |=> compare_match_event;
	endproperty
	a_match_event: assert property (p_match_event) else $error("match event missing");
	property p_xtal;
		async_clock_select && ext_clock_enable |=> !crystal_osc_run && ext_clock_input_enable;
	endproperty
	a_xtal: assert property (p_xtal) else $error("crystal runs under external clock");
	property p_busy_set;
		s_cmp_async_write |=> busy[tat_pkg::IDX_CMP] && compare_value == $past(compare_value);
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("busy not set");
	property p_read_hold;
		reg_rd && reg_addr == tat_pkg::OFS_COMPARE |=> reg_rdata == $past(hold[tat_pkg::IDX_CMP]);
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("compare read wrong");
	property p_transfer;
		s_cmp_last_edge |=> !busy[tat_pkg::IDX_CMP] && compare_value == $past(hold[tat_pkg::IDX_CMP]);
	endproperty
	a_transfer: assert property (p_transfer) else $error("transfer did not land");
	property p_ctc_clear;
		timer_tick && waveform_mode_select == tat_pkg::WGM_CTC && counter_value == compare_value
			&& !load[tat_pkg::IDX_CNT] |=> counter_value == tat_pkg::BOTTOM;
	endproperty
	a_ctc_clear: assert property (p_ctc_clear) else $error("CTC clear missed");
	property p_sync_busy;
		!async_clock_select |=> busy == '0;
	endproperty
	a_sync_busy: assert property (p_sync_busy) else $error("busy in sync mode");

endmodule : tat_timer
`default_nettype wire

/* File: sim/tb_async_timer_compare_output.sv */
/* Self-checking bench for the asynchronous 8-bit timer with compare output.
   Assumes tat_pkg and tat_timer compiled first; one 20 MHz clock. */
`timescale 1ns/10ps
`default_nettype none
module tb_async_timer_compare_output;
	// ---------------------------------------------
	// signals, clock and slow oscillator
	// ---------------------------------------------
	logic       mclk = 1'b0;
	logic       reset = 1'b1;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic       osc_input_pin = 1'b0;
	logic [2:0] osc_div = 3'h0;
	logic [7:0] reg_rdata;
	logic       pin, oe, evt, xtal, ext;
	int         n_errors = 0;
	int         tests_run = 0;
	int         n;
	// rows: address, write data, expected read back
	localparam logic [17:0] ROWS [4] = '{{2'h1, 8'h7E, 8'h7E}, {2'h2, 8'hA5, 8'hA5},
		{2'h3, 8'hE7, 8'h00}, {2'h0, 8'hC8, 8'h48}};
	localparam int SH [4] = '{0, 3, 5, 6};
	always #25 mclk = ~mclk;
	// eight mclk per oscillator period, twice the four-to-one minimum
	always @(posedge mclk) begin
		osc_div <= osc_div + 3'h1;
		osc_input_pin <= osc_div[2];
	end
	tat_timer u_tat_timer (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_input_pin(osc_input_pin),
		.compare_output_pin(pin), .compare_output_enable(oe), .compare_match_event(evt),
		.crystal_osc_run(xtal), .ext_clock_input_enable(ext));
	// ---------------------------------------------
	// bus and check tasks
	// ---------------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
	endtask : rd
	task automatic setup(input logic [7:0] ctl, input logic [7:0] cmp);
		wr(2'h0, ctl & 8'hF8);
		wr(2'h1, 8'h00);
		wr(2'h2, cmp);
		wr(2'h0, ctl);
	endtask : setup
	// counts edges up to the next match pulse; a miss ends the run
	task automatic wait_evt(input int lim);
		n = 0;
		do begin
			@(posedge mclk);
			#1 n++;
		end while (evt !== 1'b1 && n < lim);
		if (evt !== 1'b1) begin
			n_errors++;
			$display("[ERR] compare_match_event expected 1 seen %b", evt);
			test_done();
		end
	endtask : wait_evt
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		rd(2'h3, 8'h00);
		rd(2'h2, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(ROWS[i][17:16], ROWS[i][15:8]);
			rd(ROWS[i][17:16], ROWS[i][7:0]);
		end
		setup(8'h11, 8'h03);
		wait_evt(20);
		chk("compare_output_enable", 1, oe);
		chk("compare_output_pin", 1, pin);
		wait_evt(300);
		chk("compare_output_pin", 0, pin);
		wr(2'h0, 8'h31);
		wait_evt(300);
		chk("compare_output_pin", 1, pin);
		wr(2'h0, 8'h21);
		wait_evt(300);
		chk("compare_output_pin", 0, pin);
		wr(2'h0, 8'h11);
		wr(2'h1, 8'h03);
		n = 0;
		repeat (10) begin
			@(posedge mclk);
			#1 if (evt === 1'b1) n++;
		end
		chk("blocked_matches", 0, 16'(n));
		// fast PWM clear then set at top; phase correct clear on up match, set on down match
		setup(8'h69, 8'h80);
		wait_evt(300);
		chk("compare_output_pin", 0, pin);
		repeat (140) @(posedge mclk);
		#1 chk("compare_output_pin", 1, pin);
		setup(8'h61, 8'h80);
		wait_evt(600);
		chk("compare_output_pin", 0, pin);
		wait_evt(600);
		chk("compare_output_pin", 1, pin);
		// compare at TOP: match ignored, TOP clear kept
		setup(8'h79, 8'hFF);
		wait_evt(300);
		chk("compare_output_pin", 0, pin);
		setup(8'h19, 8'h0F);
		wait_evt(40);
		wait_evt(40);
		chk("match_period", 16'h0010, 16'(n));
		for (int i = 0; i < 4; i++) begin
			setup(8'h11 + 8'(i), 8'h03);
			wait_evt(20000);
			wait_evt(20000);
			chk("match_period", 16'h0100 << SH[i], 16'(n));
		end
		wr(2'h3, 8'h08);
		@(posedge mclk);
		#1 chk("crystal_osc_run", 1, xtal);
		wr(2'h3, 8'h10);
		wr(2'h3, 8'h18);
		@(posedge mclk);
		#1 chk("ext_clock_input_enable", 1, ext);
		chk("crystal_osc_run", 0, xtal);
		wr(2'h2, 8'h55);
		rd(2'h3, 8'h1A);
		repeat (24) @(posedge mclk);
		rd(2'h3, 8'h18);
		rd(2'h2, 8'h55);
		// async ticks follow the pin, eight mclk each
		wr(2'h0, 8'h11);
		wait_evt(3000);
		wait_evt(3000);
		chk("match_period", 16'h0800, 16'(n));
		@(posedge mclk);
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		rd(2'h3, 8'h00);
		test_done();
	end
endmodule : tb_async_timer_compare_output
`default_nettype wire
